// ===== common/lcd_defs.vh
// Register map constants for the laser current setting and reading bank.
// Assumes inclusion by bare name from design files.
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH

`define LCD_CMD_READING   8'h00
`define LCD_CMD_SOURCE    8'h01
`define LCD_CMD_MOD_SET   8'h02
`define LCD_CMD_PWR_LIM   8'h03

`define LCD_DATA_W        16
`define LCD_FIELD_W       10
`define LCD_LIMIT_W       7
`define LCD_LIMIT_SHIFT   3

`define LCD_RST_SETTING   10'h000
`define LCD_RST_READING   10'h000
`define LCD_RST_LIMIT     7'h00

`define LCD_SYNC_STAGES   2

`endif

// ===== core/lcd_sync.v
// Two-stage level synchroniser for single-bit inputs from other domains.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lcd_sync (
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Level
  input  wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire

// ===== core/lcd_regs.v
// Register bank: converter reading, two current settings, power limit.
// Assumes the serial-bus engine gives one-cycle read and write strobes
// with a command code; converter results come with a one-cycle valid.
// Mode and controller levels may come from any domain; both are synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_defs.vh"
module lcd_regs (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Register access from the serial-bus engine
  input  wire [7:0]  cmd_code,
  input  wire        wr_stb,
  input  wire [15:0] wr_data,
  input  wire        rd_stb,
  output reg  [15:0] rd_data_ff,
  output reg         rd_valid_ff,
  // Mode and controller state, pins from other logic
  input  wire        auto_power_mode,
  input  wire        power_controller_active,
  // Converter results, same clock
  input  wire        conv_valid,
  input  wire [9:0]  conv_code,
  // Settings to the current sources
  output reg  [9:0]  source_current_setting_ff,
  output reg  [9:0]  modulation_current_setting_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Mode levels cross from other logic, so synchronise them

  localparam NUM_LVL  = 2;
  localparam LVL_AUTO = 0;
  localparam LVL_CTRL = 1;

  wire [NUM_LVL-1:0] lvl_async;
  wire [NUM_LVL-1:0] lvl_sync;
  wire               auto_mode_sync;
  wire               ctrl_busy_sync;

  assign lvl_async[LVL_AUTO] = auto_power_mode;
  assign lvl_async[LVL_CTRL] = power_controller_active;

  // Each level resolves on its own; the two may differ by a cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LVL; gi = gi + 1) begin : g_sync
      lcd_sync u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (lvl_async[gi]),
        .dout  (lvl_sync[gi])
      );
    end
  endgenerate

  assign auto_mode_sync = lvl_sync[LVL_AUTO];
  assign ctrl_busy_sync = lvl_sync[LVL_CTRL];

  ////////////////////////////////////////////////////////////////////////
  // Converter reading

  reg  [9:0] reading_ff;
  reg  [9:0] nxt_reading;

  // Converter shares this clock, so its valid needs no synchroniser
  // Codes are stored raw; scaling by range is done in software
  always @* begin
    nxt_reading = reading_ff;
    if (conv_valid) begin
      nxt_reading = conv_code;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reading_ff <= `LCD_RST_READING;
    end else begin
      reading_ff <= nxt_reading;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power limit, tracks the monitor reading in automatic power mode

  reg  [6:0] limit_ff;
  reg  [6:0] nxt_limit;
  wire       limit_load;

  // Left untouched in constant current mode: holds its last value, zero after reset
  assign limit_load = conv_valid && auto_mode_sync;

  // The top seven code bits serve as the coarse limit
  always @* begin
    nxt_limit = limit_ff;
    if (limit_load) begin
      nxt_limit = conv_code[9:`LCD_LIMIT_SHIFT];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      limit_ff <= `LCD_RST_LIMIT;
    end else begin
      limit_ff <= nxt_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Current settings, write-gated by the controller

  wire       sel_source;
  wire       sel_modul;
  wire       wr_ok;
  reg  [9:0] nxt_source_setting;
  reg  [9:0] nxt_modul_setting;

  assign sel_source = (cmd_code == `LCD_CMD_SOURCE);
  assign sel_modul  = (cmd_code == `LCD_CMD_MOD_SET);

  // Gated on the synchronised level: a write racing the enable edge
  // may still land, so the host idles the controller first
  assign wr_ok = wr_stb && !ctrl_busy_sync;

  always @* begin
    nxt_source_setting = source_current_setting_ff;
    if (wr_ok && sel_source) begin
      nxt_source_setting = wr_data[9:0];
    end
  end

  always @* begin
    nxt_modul_setting = modulation_current_setting_ff;
    if (wr_ok && sel_modul) begin
      nxt_modul_setting = wr_data[9:0];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      source_current_setting_ff <= `LCD_RST_SETTING;
    end else begin
      source_current_setting_ff <= nxt_source_setting;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modulation_current_setting_ff <= `LCD_RST_SETTING;
    end else begin
      modulation_current_setting_ff <= nxt_modul_setting;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unknown codes read zero

  wire [15:0] word_reading;
  wire [15:0] word_source;
  wire [15:0] word_modul;
  wire [15:0] word_limit;
  reg  [15:0] nxt_rd_data;
  reg         nxt_rd_valid;

  // Zero padding keeps reserved bits low whatever the host wrote
  assign word_reading = {6'h00, reading_ff};
  assign word_source  = {6'h00, source_current_setting_ff};
  assign word_modul   = {6'h00, modulation_current_setting_ff};
  assign word_limit   = {9'h000, limit_ff};

  // Reading sits at code 0x00, below the two settings and the power limit
  always @* begin
    case (cmd_code)
      `LCD_CMD_READING: nxt_rd_data = word_reading;
      `LCD_CMD_SOURCE:  nxt_rd_data = word_source;
      `LCD_CMD_MOD_SET: nxt_rd_data = word_modul;
      `LCD_CMD_PWR_LIM: nxt_rd_data = word_limit;
      default:          nxt_rd_data = 16'h0000;
    endcase
  end

  // Answer follows every strobe, mapped code or not
  always @* begin
    nxt_rd_valid = rd_stb;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // Held between reads, so a slow host may still pick it up
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 16'h0000;
    end else if (rd_stb) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/lcd_regs_properties.sv
// Port checker for the current register bank.
// Assumes modes settle three edges before use.
`timescale 1ns/10ps
`default_nettype none
module lcd_regs_properties (
  input wire logic clock, rst_n, wr_stb, rd_stb, rd_valid_ff, conv_valid,
  input wire logic auto_power_mode, power_controller_active,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data, rd_data_ff,
  input wire logic [9:0] conv_code, source_current_setting_ff,
  input wire logic [9:0] modulation_current_setting_ff
);
  wire [7:0] c = cmd_code;
  wire [15:0] q = rd_data_ff;
  wire [9:0] s = source_current_setting_ff;
  wire p = power_controller_active;
  logic [9:0] lc_ff;
  logic [1:0] am_ff;
  logic [6:0] lim_ff;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) begin
      lc_ff <= 10'h000;
      am_ff <= 2'h0;
      lim_ff <= 7'h00;
    end else begin
      am_ff <= {am_ff[0], auto_power_mode};
      if (conv_valid) lc_ff <= conv_code;
      // Limit only follows readings taken after the mode has crossed over
      if (conv_valid && am_ff[1]) lim_ff <= conv_code[9:3];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rv; rd_stb |=> rd_valid_ff; endproperty
  a_rv: assert property (p_rv) else $error("no answer");
  property p_res; rd_valid_ff |-> q[15:10] == 6'h00; endproperty
  a_res: assert property (p_res) else $error("reserved set");
  property p_set; rd_stb && c == 8'h01 |=> q == {6'h00, $past(s)}; endproperty
  a_set: assert property (p_set) else $error("bad setting");
  property p_blk; p [*3] |=> $stable(s); endproperty
  a_blk: assert property (p_blk) else $error("gated write");
  property p_wr; !p [*3] ##0 wr_stb && c == 8'h01 |=>
    {6'h00, s} == ($past(wr_data) & 16'h03ff); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_rd0; rd_stb && c == 8'h00 && !conv_valid |=>
    q == {6'h00, lc_ff}; endproperty
  a_rd0: assert property (p_rd0) else $error("bad reading");
  property p_lim; auto_power_mode [*3] ##0 rd_stb && c == 8'h03 && !conv_valid
    |=> q == {9'h000, lim_ff}; endproperty
  a_lim: assert property (p_lim) else $error("bad limit");
  property p_unk; rd_stb && c > 8'h03 |=> q == 16'h0000; endproperty
  a_unk: assert property (p_unk) else $error("unmapped read");
  c_blk: cover property (wr_stb && p);
  c_auto: cover property (conv_valid && auto_power_mode);
  c_unk: cover property (rd_stb && c > 8'h03);
endmodule
`default_nettype wire

// ===== testbench/lcd_host.sv
// Host model issuing one-cycle register strobes.
// Assumes calls come after reset release.
`timescale 1ns/10ps
`default_nettype none
module lcd_host (
  input wire logic   clock,
  output logic [7:0]  cmd_code,
  output logic        wr_stb, rd_stb,
  output logic [15:0] wr_data
);
  initial {cmd_code, wr_stb, rd_stb, wr_data} = 26'h0;
  task automatic acc(input logic w, input logic [7:0] cc,
                     input logic [15:0] d);
    @(posedge clock);
    cmd_code <= cc;
    wr_data <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clock);
    {wr_stb, rd_stb} <= 2'h0;
    wr_data <= ~d; // Released data is not left valid
  endtask
endmodule
`default_nettype wire

// ===== testbench/lcd_regs_tb.sv
// Bench for the register bank, host model on the command port.
// Assumes fixed one-cycle answers, so no open waits.
`timescale 1ns/10ps
`default_nettype none
module lcd_regs_tb;
  logic clock, rst_n, wr_stb, rd_stb, rd_valid_ff, conv_valid;
  logic auto_power_mode, power_controller_active;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data_ff;
  logic [9:0] conv_code, source_current_setting_ff;
  logic [9:0] modulation_current_setting_ff;
  int num_errors, tests_run;
  lcd_host h (.*);
  lcd_regs dut (.*);
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    h.acc(1'b0, a, 16'h0000);
    #1 chk(rd_data_ff, e);
    chk({15'h0000, rd_valid_ff}, 16'h0001);
  endtask
  task automatic md(input logic a, b);
    @(posedge clock);
    auto_power_mode <= a;
    power_controller_active <= b;
    repeat (3) @(posedge clock);
  endtask
  task automatic cnv(input logic [9:0] v);
    @(posedge clock);
    conv_valid <= 1'b1;
    conv_code <= v;
    @(posedge clock);
    conv_valid <= 1'b0;
  endtask
  task automatic t_rst;
    for (int i = 0; i < 4; i++) rdc(i[7:0], 16'h0000);
    $display("reset done");
  endtask
  task automatic t_wr;
    h.acc(1'b1, 8'h01, 16'hfd55);
    h.acc(1'b1, 8'h02, 16'hffff);
    rdc(8'h02, 16'h03ff);
    chk({6'h00, source_current_setting_ff}, 16'h0155);
    md(1'b0, 1'b1);
    h.acc(1'b1, 8'h01, 16'h0000);
    h.acc(1'b1, 8'h02, 16'h0000);
    h.acc(1'b1, 8'h03, 16'hffff);
    rdc(8'h01, 16'h0155);
    chk({6'h00, modulation_current_setting_ff}, 16'h03ff);
    rdc(8'h03, 16'h0000);
    rdc(8'h09, 16'h0000);
    $display("writes done");
  endtask
  task automatic t_adc;
    md(1'b0, 1'b0);
    h.acc(1'b1, 8'h01, 16'h0123);
    #1 chk({6'h00, source_current_setting_ff}, 16'h0123);
    cnv(10'h3ff);
    rdc(8'h00, 16'h03ff);
    md(1'b1, 1'b0);
    cnv(10'h2c9);
    rdc(8'h00, 16'h02c9);
    rdc(8'h03, 16'h0059);
    $display("readings done");
  endtask
  task automatic t_mid;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk({6'h00, source_current_setting_ff}, 16'h0000);
    chk({6'h00, modulation_current_setting_ff}, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b1;
    t_rst;
    $display("mid reset done");
  endtask
  task automatic wrap_up;
    $display("checks %0d bad %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    {auto_power_mode, power_controller_active, conv_valid} = 3'h0;
    conv_code = 10'h000;
    num_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_rst;
    t_wr;
    t_adc;
    t_mid;
    wrap_up;
  end
endmodule
bind lcd_regs lcd_regs_properties chk_i (.*);
`default_nettype wire
